// ===== design/lpms_level_decode.sv
// Decoder from status-word mode bits to a sleep level
`timescale 1ns/100ps
module lpms_level_decode (
	input wire logic [lpms_pkg::SW_WIDTH-1:0] status_word_i,
	output logic [2:0] level_o,
	output logic deepest_o
);
	import lpms_pkg::*;

	// Map halt, oscillator and clock generator bits onto a level
	always_comb begin
		level_o = LVL_ACTIVE;
		if (status_word_i[POS_CPU_HALT]) begin
			case ({status_word_i[POS_CLK_GEN1], status_word_i[POS_CLK_GEN0]})
				2'h0: level_o = LVL_ZERO;
				2'h1: level_o = LVL_ONE;
				2'h2: level_o = LVL_TWO;
				default: level_o = status_word_i[POS_OSC_OFF] ? LVL_FOUR : LVL_THREE;
			endcase
		end
		deepest_o = (level_o == LVL_FOUR);
	end
endmodule

// ===== design/lpms_sequencer.sv
// Low-power mode sequencer: sleep levels, service entry and core-off sleep
//
// Functional notes
// - Any enabled interrupt wakes the device from sleep levels zero to four.
// - Service entry pushes program counter and status word onto the stack.
// - Service entry clears halt, oscillator disable and clock generator one bits.
// - Return from interrupt restores the status word and the previous sleep level.
// - A modified stacked status word selects a new mode on return.
// - Shutdown control then level-four bits disables the core regulator.
// - Registers and memory are lost while in core-off sleep.
// - Every core-off exit produces a full brownout class reset.
// - Core-off exits only on reset pin, power cycle or I/O wake.
// - Rtc variant also wakes on rtc events; rtc keeps running.
// - No-clock variant keeps every clock source inactive throughout.
// - A source already flagged at entry cannot wake from core-off sleep.
// - Enabled wake functions work even with global interrupt enable low.
// - With global enable low, a wake coinciding with entry may be lost.
// - After core-off wake and boot, execution resumes at the reset vector.
// - Core-off wake sets the deep-sleep wake flag.
// - Reset-cause vector reads the core-off code after such a wake.
// - Pin states latch on core-off entry and hold until software release.
// - Halt, oscillator and clock generator bits select the sleep level.
// - Setting mode-control bits takes effect immediately.
`timescale 1ns/100ps
module lpms_sequencer #(
	parameter int NUM_IO_WAKE = 8,
	parameter int NUM_PINS = 16
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [lpms_pkg::SW_WIDTH-1:0] status_word_i,
	input wire logic status_word_we_i,
	input wire logic [lpms_pkg::SW_WIDTH-1:0] pc_i,
	input wire logic irq_pending_i,
	input wire logic return_from_interrupt_i,
	input wire logic [lpms_pkg::SW_WIDTH-1:0] stacked_status_word_i,
	input wire logic regulator_shutdown_ctl_i,
	input wire logic rtc_variant_i,
	input wire logic reset_pin_n_i,
	input wire logic power_cycle_i,
	input wire logic [NUM_IO_WAKE-1:0] io_wake_i,
	input wire logic [NUM_IO_WAKE-1:0] io_wake_en_i,
	input wire logic rtc_wake_i,
	input wire logic rtc_wake_en_i,
	input wire logic [NUM_PINS-1:0] pin_state_i,
	input wire logic pin_release_i,
	input wire logic wake_flag_clear_i,
	output logic [lpms_pkg::SW_WIDTH-1:0] processor_status_word_o,
	output logic [2:0] sleep_level_o,
	output logic core_clock_en_o,
	output logic push_valid_o,
	output logic [lpms_pkg::SW_WIDTH-1:0] push_pc_o,
	output logic [lpms_pkg::SW_WIDTH-1:0] push_sw_o,
	output logic regulator_en_o,
	output logic clocks_en_o,
	output logic rtc_run_o,
	output logic retention_lost_o,
	output logic brownout_class_reset_o,
	output logic [lpms_pkg::SW_WIDTH-1:0] boot_vector_o,
	output logic deep_sleep_wake_flag_o,
	output logic [7:0] reset_cause_vector_o,
	output logic pins_latched_o,
	output logic [NUM_PINS-1:0] pin_hold_o
);
	import lpms_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	lpms_state_t state_r;
	logic [SW_WIDTH-1:0] sw_r;
	logic [2:0] level;
	logic deepest;
	logic [2:0] bor_cnt_r;
	logic [NUM_IO_WAKE-1:0] io_sync;
	logic [1:0] misc_sync;
	logic rst_pin_n_s;
	logic rtc_s;
	logic [NUM_IO_WAKE-1:0] io_armed_r;
	logic rtc_armed_r;
	logic [NUM_IO_WAKE-1:0] io_prev_r;
	logic rtc_prev_r;
	logic core_off_wake;
	logic core_off_entry;
	logic [SW_WIDTH-1:0] live_sw;

	// ****************************************
	// Input synchronisers and level decode
	// ****************************************
	lpms_sync #(.WIDTH(NUM_IO_WAKE)) u_io_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.async_i(io_wake_i),
		.sync_o(io_sync)
	);

	lpms_sync #(.WIDTH(2)) u_misc_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.async_i({~reset_pin_n_i, rtc_wake_i}),
		.sync_o(misc_sync)
	);

	// Pin is carried inverted so the zero reset value means idle, not a reset request
	assign rst_pin_n_s = ~misc_sync[1];
	assign rtc_s = misc_sync[0];

	// Live status word includes a write in this cycle
	assign live_sw = status_word_we_i ? status_word_i : sw_r;

	lpms_level_decode u_decode (
		.status_word_i(live_sw),
		.level_o(level),
		.deepest_o(deepest)
	);

	// Core-off entry needs shutdown control plus level-four bits
	assign core_off_entry = deepest && regulator_shutdown_ctl_i;

	// Rising edge of an armed I/O source, or of armed rtc in the rtc variant, wakes; flags need no global enable
	always_comb begin
		core_off_wake = power_cycle_i || !rst_pin_n_s;
		core_off_wake = core_off_wake || |(io_sync & ~io_prev_r & io_armed_r);
		if (rtc_variant_i) begin
			core_off_wake = core_off_wake || (rtc_s && !rtc_prev_r && rtc_armed_r);
		end
	end

	// ****************************************
	// Sequencer state
	// ****************************************
	// Main state machine
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= ST_RUN;
		end else if (ce_i) begin
			case (state_r)
				ST_RUN: begin
					if (core_off_entry) begin
						state_r <= ST_CORE_OFF;
					end else if (live_sw[POS_CPU_HALT] && irq_pending_i) begin
						state_r <= ST_PUSH;
					end else if (live_sw[POS_CPU_HALT]) begin
						state_r <= ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					if (core_off_entry) begin
						state_r <= ST_CORE_OFF;
					end else if (irq_pending_i) begin
						state_r <= ST_PUSH;
					end else if (!live_sw[POS_CPU_HALT]) begin
						state_r <= ST_RUN;
					end
				end
				ST_PUSH: state_r <= ST_RUN;
				ST_CORE_OFF: begin
					if (core_off_wake) begin
						state_r <= ST_BOR;
					end
				end
				ST_BOR: begin
					if (bor_cnt_r == 3'(BOR_HOLD_CYCLES - 1)) begin
						state_r <= ST_RUN;
					end
				end
				default: state_r <= ST_RUN;
			endcase
		end
	end

	// Brownout pulse length counter
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			bor_cnt_r <= 3'h0;
		end else if (ce_i) begin
			bor_cnt_r <= (state_r == ST_BOR) ? bor_cnt_r + 3'h1 : 3'h0;
		end
	end

	// Status word: writes, service clear, return restore, reset clear
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sw_r <= '0;
		end else if (ce_i) begin
			if (state_r == ST_BOR || state_r == ST_CORE_OFF) begin
				sw_r <= '0;
			end else if (state_r == ST_PUSH) begin
				sw_r[POS_CPU_HALT] <= 1'b0;
				sw_r[POS_OSC_OFF] <= 1'b0;
				sw_r[POS_CLK_GEN1] <= 1'b0;
			end else if (return_from_interrupt_i) begin
				sw_r <= stacked_status_word_i;
			end else if (status_word_we_i) begin
				sw_r <= status_word_i;
			end
		end
	end

	// Stack push pair captured at service entry
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			push_pc_o <= '0;
			push_sw_o <= '0;
		end else if (ce_i) begin
			if (state_r != ST_PUSH && state_r != ST_CORE_OFF && irq_pending_i) begin
				push_pc_o <= pc_i;
				push_sw_o <= live_sw;
			end
		end
	end

	// Arm wake sources at entry; a source already set is not armed
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			io_armed_r <= '0;
			rtc_armed_r <= 1'b0;
			io_prev_r <= '0;
			rtc_prev_r <= 1'b0;
		end else if (ce_i) begin
			io_prev_r <= io_sync;
			rtc_prev_r <= rtc_s;
			if (state_r != ST_CORE_OFF) begin
				io_armed_r <= io_wake_en_i & ~io_sync;
				rtc_armed_r <= rtc_wake_en_i & ~rtc_s;
			end
		end
	end

	// Wake flag and reset cause; set wins over clear
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			deep_sleep_wake_flag_o <= 1'b0;
			reset_cause_vector_o <= RST_CAUSE_NONE;
		end else if (ce_i) begin
			if (state_r == ST_CORE_OFF && core_off_wake) begin
				deep_sleep_wake_flag_o <= 1'b1;
				reset_cause_vector_o <= RST_CAUSE_CORE_OFF;
			end else if (wake_flag_clear_i) begin
				deep_sleep_wake_flag_o <= 1'b0;
				reset_cause_vector_o <= RST_CAUSE_NONE;
			end
		end
	end

	// Pin latch held through the wake reset until release
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pins_latched_o <= 1'b0;
			pin_hold_o <= '0;
		end else if (ce_i) begin
			if (state_r != ST_CORE_OFF && core_off_entry && !pins_latched_o) begin
				pins_latched_o <= 1'b1;
				pin_hold_o <= pin_state_i;
			end else if (pin_release_i && state_r == ST_RUN) begin
				pins_latched_o <= 1'b0;
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign processor_status_word_o = sw_r;
	assign sleep_level_o = (state_r == ST_PUSH) ? LVL_ACTIVE : level;
	assign core_clock_en_o = (state_r == ST_RUN || state_r == ST_PUSH) && !live_sw[POS_CPU_HALT];
	assign push_valid_o = (state_r == ST_PUSH);
	assign regulator_en_o = (state_r != ST_CORE_OFF);
	assign clocks_en_o = (state_r != ST_CORE_OFF) && !deepest;
	assign rtc_run_o = (state_r != ST_CORE_OFF) || rtc_variant_i;
	assign retention_lost_o = (state_r == ST_CORE_OFF);
	assign brownout_class_reset_o = (state_r == ST_BOR);
	assign boot_vector_o = RESET_VECTOR_ADDR;

	// ****************************************
	// Checks
	// ****************************************
	a_regoff_on_entry: assert property (@(posedge clk_i) disable iff (reset_i)
		(ce_i && state_r == ST_RUN && core_off_entry) |=> !regulator_en_o)
		else $error("regulator not disabled on core-off entry");
	a_wake_to_bor: assert property (@(posedge clk_i) disable iff (reset_i)
		(ce_i && state_r == ST_CORE_OFF && core_off_wake) |=> brownout_class_reset_o)
		else $error("core-off wake did not reset");
	a_bor_length: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(brownout_class_reset_o) && ce_i |-> (brownout_class_reset_o && ce_i)[*4] ##1
		!brownout_class_reset_o)
		else $error("brownout pulse length wrong");
	a_wake_flag_set: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(brownout_class_reset_o) |-> deep_sleep_wake_flag_o)
		else $error("wake flag missing");
	a_cause_code: assert property (@(posedge clk_i) disable iff (reset_i)
		deep_sleep_wake_flag_o |-> reset_cause_vector_o == RST_CAUSE_CORE_OFF)
		else $error("reset cause code wrong");
	a_pins_held: assert property (@(posedge clk_i) disable iff (reset_i)
		(pins_latched_o && !pin_release_i) |=> pins_latched_o)
		else $error("pin latch dropped");
	a_service_clear: assert property (@(posedge clk_i) disable iff (reset_i)
		(ce_i && push_valid_o) |=> !sw_r[POS_CPU_HALT] && !sw_r[POS_OSC_OFF] &&
		!sw_r[POS_CLK_GEN1])
		else $error("mode bits not cleared");
	a_sleep_wake: assert property (@(posedge clk_i) disable iff (reset_i)
		(ce_i && state_r == ST_SLEEP && irq_pending_i && !core_off_entry) |=> push_valid_o)
		else $error("interrupt did not wake");
	a_no_clocks: assert property (@(posedge clk_i) disable iff (reset_i)
		retention_lost_o |-> !clocks_en_o && (rtc_run_o == rtc_variant_i))
		else $error("clock active in core-off sleep");
	a_return_from_interrupt_restore: assert property (@(posedge clk_i) disable iff (reset_i)
		(ce_i && return_from_interrupt_i && state_r == ST_RUN) |=>
		sw_r == $past(stacked_status_word_i))
		else $error("status word not restored");
endmodule

// ===== design/lpms_sync.sv
// Two-stage synchroniser for pin-side wake inputs
`timescale 1ns/100ps
module lpms_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_r;

	// First stage feeds only the second
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			meta_r <= '0;
			sync_o <= '0;
		end else if (ce_i) begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end
endmodule

// ===== inc/lpms_pkg.sv
// Package of constants and types for the low-power mode sequencer
package lpms_pkg;
	// Status word bit positions of the mode-control bits
	localparam int SW_WIDTH = 16;
	localparam int POS_GIE = 3;
	localparam int POS_CPU_HALT = 4;
	localparam int POS_OSC_OFF = 5;
	localparam int POS_CLK_GEN0 = 6;
	localparam int POS_CLK_GEN1 = 7;
	// Sleep levels, five clock-gated levels plus active
	localparam logic [2:0] LVL_ACTIVE = 3'h0;
	localparam logic [2:0] LVL_ZERO = 3'h1;
	localparam logic [2:0] LVL_ONE = 3'h2;
	localparam logic [2:0] LVL_TWO = 3'h3;
	localparam logic [2:0] LVL_THREE = 3'h4;
	localparam logic [2:0] LVL_FOUR = 3'h5;
	// Reset-cause code after a core-off wake-up
	localparam logic [7:0] RST_CAUSE_NONE = 8'h00;
	localparam logic [7:0] RST_CAUSE_CORE_OFF = 8'h08;
	// System reset vector location
	localparam logic [15:0] RESET_VECTOR_ADDR = 16'hffff;
	// Cycles a brownout reset pulse is held
	localparam int BOR_HOLD_CYCLES = 4;
	// Sequencer states
	typedef enum logic [4:0] {
		ST_RUN = 5'b00001,
		ST_PUSH = 5'b00010,
		ST_SLEEP = 5'b00100,
		ST_CORE_OFF = 5'b01000,
		ST_BOR = 5'b10000
	} lpms_state_t;
endpackage

// ===== verification/lpms_core_model.sv
// Core-side partner model: interrupt stack slot and return
`timescale 1ns/100ps
module lpms_core_model (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic push_valid_i,
	input wire logic [lpms_pkg::SW_WIDTH-1:0] push_sw_i,
	input wire logic ret_go_i,
	input wire logic [lpms_pkg::SW_WIDTH-1:0] edit_clr_i,
	output logic return_from_interrupt_o,
	output logic [lpms_pkg::SW_WIDTH-1:0] stacked_status_word_o
);
	import lpms_pkg::*;
	logic [SW_WIDTH-1:0] stack_r;
	// Stack slot written during service entry
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			stack_r <= 16'h0000;
		end else if (push_valid_i) begin
			stack_r <= push_sw_i;
		end
	end
	// Pop with optional handler edit; inverse shown when not popping
	assign return_from_interrupt_o = ret_go_i;
	assign stacked_status_word_o = ret_go_i ? (stack_r & ~edit_clr_i) : ~stack_r;
endmodule

// ===== verification/lpms_sequencer_tb_top.sv
// Self-checking bench for the low-power mode sequencer
`timescale 1ns/100ps
module lpms_sequencer_tb_top;
	import lpms_pkg::*;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic sw_we = 1'b0, irq = 1'b0, ret_go = 1'b0, shut = 1'b0, rtc_var = 1'b0;
	logic rst_pin_n = 1'b1, pwr = 1'b0, rtc_wk = 1'b0, rel = 1'b0, fclr = 1'b0;
	logic [15:0] sw_in = 16'h0000, pc = 16'h1234, clr = 16'h0000, pins = 16'h0000;
	logic [7:0] io_wk = 8'h00;
	logic ret, push_v, core_clk, reg_en, clk_en, rtc_run, lost, bor, flag, latched;
	logic [15:0] stk, psw, ppc, psw_push, bootv, hold;
	logic [2:0] lvl;
	logic [7:0] cause;
	logic [15:0] enc [5] = '{16'h0010, 16'h0050, 16'h0090, 16'h00d0, 16'h00f0};
	int n_mismatch = 0;
	int tests_run = 0;
	int cyc = 0;
	// ************
	// Clock, parts and timeout
	// ************
	always #4 clk_i = ~clk_i;
	lpms_core_model i_core (.clk_i(clk_i), .reset_i(reset_i), .push_valid_i(push_v),
		.push_sw_i(psw_push), .ret_go_i(ret_go), .edit_clr_i(clr),
		.return_from_interrupt_o(ret), .stacked_status_word_o(stk));
	lpms_sequencer i_dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1),
		.status_word_i(sw_in), .status_word_we_i(sw_we), .pc_i(pc), .irq_pending_i(irq),
		.return_from_interrupt_i(ret), .stacked_status_word_i(stk),
		.regulator_shutdown_ctl_i(shut), .rtc_variant_i(rtc_var), .reset_pin_n_i(rst_pin_n),
		.power_cycle_i(pwr), .io_wake_i(io_wk), .io_wake_en_i(8'h03), .rtc_wake_i(rtc_wk),
		.rtc_wake_en_i(1'b1), .pin_state_i(pins), .pin_release_i(rel),
		.wake_flag_clear_i(fclr), .processor_status_word_o(psw), .sleep_level_o(lvl),
		.core_clock_en_o(core_clk), .push_valid_o(push_v), .push_pc_o(ppc),
		.push_sw_o(psw_push), .regulator_en_o(reg_en), .clocks_en_o(clk_en),
		.rtc_run_o(rtc_run), .retention_lost_o(lost), .brownout_class_reset_o(bor),
		.boot_vector_o(bootv), .deep_sleep_wake_flag_o(flag),
		.reset_cause_vector_o(cause), .pins_latched_o(latched), .pin_hold_o(hold));
	// Cut a hang short
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			end_sim();
		end
	end
	// ************
	// Shared tasks
	// ************
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [15:0] w, input logic pend);
		@(posedge clk_i);
		sw_in <= w;
		sw_we <= 1'b1;
		irq <= pend;
		@(posedge clk_i);
		sw_we <= 1'b0;
		irq <= 1'b0;
		#1;
	endtask
	// Pulse an interrupt when asked, then wait for service entry
	task automatic wake(input logic [15:0] w, input logic pulse);
		int k;
		if (pulse) begin
			@(posedge clk_i);
			irq <= 1'b1;
			@(posedge clk_i);
			irq <= 1'b0;
			#1;
		end
		for (k = 0; k < 4 && push_v !== 1'b1; k++) tick(1);
		chk("push_valid", 1, push_v);
		chk("push_sw", w, psw_push);
		chk("push_pc", pc, ppc);
		tick(1);
		chk("sw_cleared", w & ~16'h00b0, psw);
		chk("core_clk", 1, core_clk);
	endtask
	task automatic pop(input logic [15:0] c);
		@(posedge clk_i);
		clr <= c;
		ret_go <= 1'b1;
		@(posedge clk_i);
		ret_go <= 1'b0;
		#1;
	endtask
	// ************
	// Scenarios
	// ************
	task automatic sleep_wake(input int i);
		logic [15:0] w;
		w = 16'h0008 | enc[i];
		wr(w, 1'b0);
		chk("level", LVL_ZERO + 3'(i), lvl);
		chk("core_clk", 0, core_clk);
		chk("clocks_en", (i == 4) ? 1'b0 : 1'b1, clk_en);
		wake(w, 1'b1);
		pop(16'h0000);
		chk("sw_restored", w, psw);
		chk("level_back", LVL_ZERO + 3'(i), lvl);
		wake(w, 1'b1);
		pop(16'h00f0);
		chk("level_new", LVL_ACTIVE, lvl);
	endtask
	task automatic early_irq();
		wr(16'h0018, 1'b1);
		wake(16'h0018, 1'b0);
		pop(16'h00f0);
	endtask
	// Core-off entry, stray events, wake from one source, release
	task automatic coff(input int src);
		int k;
		logic [15:0] pat;
		pat = 16'ha5c3 ^ 16'(src);
		@(posedge clk_i);
		pins <= pat;
		rtc_var <= (src == 1);
		shut <= 1'b1;
		io_wk <= 8'h02;
		tick(3);
		wr(src[0] ? 16'h00f8 : 16'h00f0, 1'b0);
		tick(2);
		chk("reg_en", 0, reg_en);
		chk("lost", 1, lost);
		chk("clocks_en", 0, clk_en);
		chk("rtc_run", src == 1, rtc_run);
		chk("hold", pat, hold);
		@(posedge clk_i);
		pins <= 16'h0000;
		rtc_wk <= (src != 1);
		io_wk <= 8'h00;
		tick(3);
		// Source high at entry rises again while off: must not wake
		@(posedge clk_i);
		io_wk <= 8'h02;
		tick(4);
		chk("stay_off", 0, reg_en);
		chk("latched", 1, latched);
		@(posedge clk_i);
		io_wk[0] <= (src == 0);
		rtc_wk <= 1'b1;
		rst_pin_n <= (src != 2);
		pwr <= (src == 3);
		@(posedge clk_i);
		rst_pin_n <= 1'b1;
		pwr <= 1'b0;
		#1;
		for (k = 0; k < 10 && bor !== 1'b1; k++) tick(1);
		chk("bor", 1, bor);
		chk("flag", 1, flag);
		chk("cause", RST_CAUSE_CORE_OFF, cause);
		chk("boot_vec", RESET_VECTOR_ADDR, bootv);
		chk("rtc_keep", 1'b1, rtc_run);
		for (k = 0; k < 12 && bor === 1'b1; k++) tick(1);
		chk("bor_len", BOR_HOLD_CYCLES, k);
		chk("sw_lost", 0, psw);
		chk("hold_kept", pat, hold);
		chk("latched_kept", 1, latched);
		@(posedge clk_i);
		rel <= 1'b1;
		fclr <= 1'b1;
		io_wk <= 8'h00;
		rtc_wk <= 1'b0;
		shut <= 1'b0;
		@(posedge clk_i);
		rel <= 1'b0;
		fclr <= 1'b0;
		tick(1);
		chk("unlatched", 0, latched);
		chk("flag_clr", 0, flag);
		chk("cause_clr", RST_CAUSE_NONE, cause);
		chk("reg_on", 1, reg_en);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		tick(1);
		chk("reg_en_rst", 1, reg_en);
		chk("cause_rst", RST_CAUSE_NONE, cause);
		for (int i = 0; i < 5; i++) sleep_wake(i);
		early_irq();
		for (int s = 0; s < 4; s++) coff(s);
		end_sim();
	end
endmodule
